// >>> core/dual_timer_cfg.svh
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH

// Register byte offsets on the bus.
`define OFS_TIMER_CTRL   8'h00
`define OFS_TIMER_MODE   8'h04
`define OFS_CLOCK_CTRL   8'h08
`define OFS_EXT_CFG      8'h0C
`define OFS_A_LOW        8'h10
`define OFS_A_HIGH       8'h14
`define OFS_B_LOW        8'h18
`define OFS_B_HIGH       8'h1C
`define OFS_STATUS       8'h20
`define OFS_IRQ_ENABLE   8'h24

// Timer control register fields.
`define RUN_A_BIT        0
`define RUN_B_BIT        1

// Timer mode register fields.
`define MODE_A_LSB       0
`define CT_A_BIT         2
`define GATE_A_BIT       3
`define MODE_B_LSB       4
`define CT_B_BIT         6
`define GATE_B_BIT       7

// Clock control register fields.
`define SCALE_LSB        0
`define SYSSEL_A_BIT     2
`define SYSSEL_B_BIT     3

// External gate configuration fields.
`define POL_A_BIT        0
`define POL_B_BIT        1

// Status and interrupt enable fields share one layout.
`define FLAG_A_BIT       0
`define FLAG_B_BIT       1

// Reset values.
`define RST_BYTE         8'h00
`define RST_PAIR         2'h0
`define RST_NIBBLE       4'h0
`define RST_WORD         32'h00000000

// Prescaled clock divisors, one per clock scale code.
`define SCALE_DIV0       8'h04
`define SCALE_DIV1       8'h08
`define SCALE_DIV2       8'h10
`define SCALE_DIV3       8'h20

`endif

// >>> core/dual_timer_pkg.sv
package dual_timer_pkg;

    typedef enum logic [1:0] {
        MODE13    = 2'b00,
        MODE16    = 2'b01,
        MODE8RL   = 2'b10,
        MODESPLIT = 2'b11
    } timer_mode_t;

    typedef logic [7:0] byte_t;

endpackage

// >>> core/prescale_divider.sv
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module prescale_divider
    import dual_timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] scaleSel,
    output logic            tick
);

    byte_t divCount_q;
    byte_t divCount_d;
    byte_t divLimit;

    always_comb begin
        unique case (scaleSel)
            2'h0: divLimit = `SCALE_DIV0;
            2'h1: divLimit = `SCALE_DIV1;
            2'h2: divLimit = `SCALE_DIV2;
            2'h3: divLimit = `SCALE_DIV3;
        endcase
    end

    // A change of scale keeps the running count; a count already at or past the new limit ticks at once.
    always_comb begin
        tick = (divCount_q >= divLimit - 8'h01);
        divCount_d = tick ? `RST_BYTE : divCount_q + 8'h01;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            divCount_q <= `RST_BYTE;
        end else begin
            divCount_q <= divCount_d;
        end
    end

endmodule // prescale_divider

// >>> core/dual_counter_timer.sv
// Behaviour
// - Each timer has own four-mode select.
// - Count is 16 bits, two byte registers.
// - Timebase: sysclk, four prescales, or pin.
// - Counter select counts falling pin edges; timer B counts its internal timebase instead while timer A is split.
// - Otherwise sysclk select picks clock or prescale.
// - 13-bit: high byte plus low five bits.
// - 13-bit wrap sets flag, may interrupt.
// - Count when run and gate allows.
// - Each gate input has own polarity bit.
// - Run bit never clears or reloads count.
// - Separate per-timer interrupt enable bits.
// - Timer B mirrors timer A, except in split mode, where it stops.
// - 16-bit mode uses all sixteen bits.
// - 8-bit reload: low counts, reloads from high.
// - Split: high byte uses B run, B flag.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module dual_counter_timer
    import dual_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        eventPinA,
    input  wire logic        eventPinB,
    input  wire logic        gateInputA,
    input  wire logic        gateInputB,
    output logic             irq
);

    // Bus state.
    logic        wrPend_q;
    logic        wrPend_d;
    logic [7:0]  wrAddr_q;
    logic [7:0]  wrAddr_d;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic        addrPhase;

    // Software-visible configuration.
    logic [1:0]  run_q;
    logic [1:0]  run_d;
    byte_t       modeReg_q;
    byte_t       modeReg_d;
    logic [3:0]  clkCtl_q;
    logic [3:0]  clkCtl_d;
    logic [1:0]  gatePol_q;
    logic [1:0]  gatePol_d;
    logic [1:0]  irqEnable_q;
    logic [1:0]  irqEnable_d;

    // Counting state.
    byte_t [1:0] low_q;
    byte_t [1:0] low_d;
    byte_t [1:0] high_q;
    byte_t [1:0] high_d;
    logic  [1:0] flag_q;
    logic  [1:0] flag_d;
    logic  [1:0] eventPrev_q;
    logic        irq_q;

    logic        preTick;
    timer_mode_t modeA;
    timer_mode_t modeB;
    logic  [1:0] counterSel;
    logic  [1:0] gateEn;
    logic  [1:0] sysSel;
    logic  [1:0] gateIn;
    logic  [1:0] eventPin;
    logic  [1:0] eventFall;
    logic  [1:0] intTick;
    logic  [1:0] srcTick;
    logic  [1:0] enabled;
    logic  [1:0] countTick;
    logic        splitA;
    logic        splitHighTick;
    logic [16:0] stepA;
    logic [16:0] stepB;
    logic  [1:0] flagSet;
    logic  [1:0] flagClr;

    prescale_divider u_prescale (
        .clk      (clk),
        .rst      (rst),
        .scaleSel (clkCtl_q[`SCALE_LSB +: 2]),
        .tick     (preTick)
    );

    assign modeA = timer_mode_t'(modeReg_q[`MODE_A_LSB +: 2]);
    assign modeB = timer_mode_t'(modeReg_q[`MODE_B_LSB +: 2]);
    assign counterSel = {modeReg_q[`CT_B_BIT], modeReg_q[`CT_A_BIT]};
    assign gateEn = {modeReg_q[`GATE_B_BIT], modeReg_q[`GATE_A_BIT]};
    assign sysSel = {clkCtl_q[`SYSSEL_B_BIT], clkCtl_q[`SYSSEL_A_BIT]};
    assign gateIn = {gateInputB, gateInputA};
    assign eventPin = {eventPinB, eventPinA};
    assign splitA = (modeA == MODESPLIT);

    // Per-timer source selection and gating. Timer B loses its pin while timer A is split.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_src
            assign eventFall[i] = eventPrev_q[i] & ~eventPin[i];
            assign intTick[i] = sysSel[i] | preTick;
            assign srcTick[i] = (counterSel[i] && !(i == 1 && splitA))
                                ? eventFall[i] : intTick[i];
            assign enabled[i] = run_q[i] & (~gateEn[i] | (gateIn[i] == gatePol_q[i]));
        end
    endgenerate

    assign countTick[0] = enabled[0] & srcTick[0];
    assign countTick[1] = enabled[1] & srcTick[1] & (modeB != MODESPLIT);
    assign splitHighTick = splitA & run_q[1] & intTick[0];

    // One increment step; returns overflow, high byte and low byte.
    function automatic logic [16:0] stepCount(timer_mode_t m, byte_t lo, byte_t hi);
        logic  ovf;
        byte_t nlo;
        byte_t nhi;
        ovf = 1'b0;
        nlo = lo;
        nhi = hi;
        unique case (m)
            MODE13: begin
                nlo[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1F) begin
                    nhi = hi + 8'h01;
                    ovf = (hi == 8'hFF);
                end
            end
            MODE16: begin
                {nhi, nlo} = {hi, lo} + 16'h0001;
                ovf = ({hi, lo} == 16'hFFFF);
            end
            MODE8RL: begin
                ovf = (lo == 8'hFF);
                nlo = ovf ? hi : lo + 8'h01;
            end
            MODESPLIT: begin
                ovf = (lo == 8'hFF);
                nlo = lo + 8'h01;
            end
        endcase
        return {ovf, nhi, nlo};
    endfunction

    assign stepA = stepCount(modeA, low_q[0], high_q[0]);
    assign stepB = stepCount(modeB, low_q[1], high_q[1]);

    // Bus: writes commit in the data phase; a read right behind a write waits one cycle.
    assign addrPhase = hsel & htrans[1] & hready;
    assign hreadyout = ~(wrPend_q & hsel & htrans[1] & ~hwrite);
    assign hresp = 1'b0;
    assign hrdata = rdData_q;

    always_comb begin
        wrPend_d = addrPhase & hwrite;
        wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
        rdData_d = rdData_q;
        if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                `OFS_TIMER_CTRL: rdData_d = {30'h0, run_q};
                `OFS_TIMER_MODE: rdData_d = {24'h0, modeReg_q};
                `OFS_CLOCK_CTRL: rdData_d = {28'h0, clkCtl_q};
                `OFS_EXT_CFG:    rdData_d = {30'h0, gatePol_q};
                `OFS_A_LOW:      rdData_d = {24'h0, low_q[0]};
                `OFS_A_HIGH:     rdData_d = {24'h0, high_q[0]};
                `OFS_B_LOW:      rdData_d = {24'h0, low_q[1]};
                `OFS_B_HIGH:     rdData_d = {24'h0, high_q[1]};
                `OFS_STATUS:     rdData_d = {30'h0, flag_q};
                `OFS_IRQ_ENABLE: rdData_d = {30'h0, irqEnable_q};
                default:         rdData_d = `RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= `RST_BYTE;
            rdData_q <= `RST_WORD;
        end else begin
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            rdData_q <= rdData_d;
        end
    end

    // Configuration registers.
    always_comb begin
        run_d = run_q;
        modeReg_d = modeReg_q;
        clkCtl_d = clkCtl_q;
        gatePol_d = gatePol_q;
        irqEnable_d = irqEnable_q;
        if (wrPend_q) begin
            unique case (wrAddr_q)
                `OFS_TIMER_CTRL: run_d = hwdata[1:0];
                `OFS_TIMER_MODE: modeReg_d = hwdata[7:0];
                `OFS_CLOCK_CTRL: clkCtl_d = hwdata[3:0];
                `OFS_EXT_CFG:    gatePol_d = hwdata[1:0];
                `OFS_IRQ_ENABLE: irqEnable_d = hwdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_q <= `RST_PAIR;
            modeReg_q <= `RST_BYTE;
            clkCtl_q <= `RST_NIBBLE;
            gatePol_q <= `RST_PAIR;
            irqEnable_q <= `RST_PAIR;
        end else begin
            run_q <= run_d;
            modeReg_q <= modeReg_d;
            clkCtl_q <= clkCtl_d;
            gatePol_q <= gatePol_d;
            irqEnable_q <= irqEnable_d;
        end
    end

    // Counters and flags. A software byte write beats a count step in the same cycle.
    always_comb begin
        low_d = low_q;
        high_d = high_q;
        flagSet = 2'h0;
        flagClr = 2'h0;
        if (countTick[0]) begin
            {flagSet[0], high_d[0], low_d[0]} = stepA;
        end
        if (splitHighTick) begin
            high_d[0] = high_q[0] + 8'h01;
            flagSet[1] = (high_q[0] == 8'hFF);
        end
        if (countTick[1]) begin
            {flagSet[1], high_d[1], low_d[1]} = {stepB[16] | flagSet[1], stepB[15:0]};
            if (splitA) begin
                flagSet[1] = splitHighTick & (high_q[0] == 8'hFF);
            end
        end
        if (wrPend_q) begin
            unique case (wrAddr_q)
                `OFS_A_LOW:  low_d[0] = hwdata[7:0];
                `OFS_A_HIGH: high_d[0] = hwdata[7:0];
                `OFS_B_LOW:  low_d[1] = hwdata[7:0];
                `OFS_B_HIGH: high_d[1] = hwdata[7:0];
                `OFS_STATUS: flagClr = hwdata[1:0];
                default: ;
            endcase
        end
        flag_d = (flag_q & ~flagClr) | flagSet;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            low_q <= {`RST_BYTE, `RST_BYTE};
            high_q <= {`RST_BYTE, `RST_BYTE};
            flag_q <= `RST_PAIR;
            eventPrev_q <= 2'h3;
            irq_q <= 1'b0;
        end else begin
            low_q <= low_d;
            high_q <= high_d;
            flag_q <= flag_d;
            eventPrev_q <= eventPin;
            irq_q <= |(flag_d & irqEnable_d);
        end
    end

    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wrap_13bit_a: assert property ((modeA == MODE13) && countTick[0] && !wrPend_q
        && low_q[0][4:0] == 5'h1F && high_q[0] == 8'hFF
        |=> flag_q[0] && high_q[0] == 8'h00 && low_q[0][4:0] == 5'h00)
        else $error("13-bit wrap did not set flag A");

    wrap_16bit_a: assert property ((modeB == MODE16) && countTick[1] && !wrPend_q
        && !splitA && {high_q[1], low_q[1]} == 16'hFFFF
        |=> flag_q[1] && {high_q[1], low_q[1]} == 16'h0000)
        else $error("16-bit wrap did not set flag B");

    reload_8bit_a: assert property ((modeA == MODE8RL) && countTick[0] && !wrPend_q
        && low_q[0] == 8'hFF
        |=> low_q[0] == $past(high_q[0]) && $stable(high_q[0]) && flag_q[0])
        else $error("8-bit reload failed");

    run_hold_a: assert property (!run_q[0] && !wrPend_q && !splitA
        |=> $stable(low_q[0]) && $stable(high_q[0]))
        else $error("timer A counted while stopped");

    gate_block_a: assert property (run_q[1] && gateEn[1] && !wrPend_q
        && gateInputB != gatePol_q[1] && !splitA
        |=> $stable(low_q[1]) && $stable(high_q[1]))
        else $error("timer B counted with gate inactive");

    event_count_a: assert property ((modeA == MODE16) && counterSel[0] && enabled[0]
        && eventPrev_q[0] && !eventPinA && !wrPend_q
        |=> {high_q[0], low_q[0]} == $past({high_q[0], low_q[0]}) + 16'h0001)
        else $error("falling edge not counted");

    sysclk_count_a: assert property ((modeA == MODE16) && !counterSel[0] && sysSel[0]
        && enabled[0] && !wrPend_q [*2]
        |=> {high_q[0], low_q[0]} == $past({high_q[0], low_q[0]}, 2) + 16'h0002)
        else $error("system clock source did not count every cycle");

    split_high_a: assert property (splitHighTick && high_q[0] == 8'hFF && !wrPend_q
        |=> flag_q[1] && high_q[0] == 8'h00)
        else $error("split high byte did not set flag B");

    irq_level_a: assert property (irq == |(flag_q & irqEnable_q))
        else $error("interrupt output does not follow masked flags");

endmodule // dual_counter_timer

// >>> verification/pin_partner.sv
`timescale 1ns/1ps

module pin_partner (
    input  wire logic clk,
    output logic      eventPinA,
    output logic      eventPinB,
    output logic      gateInputA,
    output logic      gateInputB
);
    // Event pins idle high so that the first low level is a real falling edge.
    initial begin
        eventPinA  = 1'b1;
        eventPinB  = 1'b1;
        gateInputA = 1'b0;
        gateInputB = 1'b0;
    end

    // Gate levels change only here, so each pin has one driver.
    task automatic setGate(input bit pinB, input bit level);
        if (pinB) gateInputB <= level;
        else gateInputA <= level;
    endtask

    // Each level stands two full clocks, so no edge is lost to the sampler.
    task automatic pulses(input bit pinB, input int n);
        repeat (n) begin
            if (pinB) eventPinB <= 1'b0;
            else eventPinA <= 1'b0;
            repeat (2) @(posedge clk);
            if (pinB) eventPinB <= 1'b1;
            else eventPinA <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule // pin_partner

// >>> verification/dual_counter_timer_tb.sv
`timescale 1ns/1ps
`include "dual_timer_cfg.svh"

module dual_counter_timer_tb;
    logic        clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        eventPinA;
    logic        eventPinB;
    logic        gateInputA;
    logic        gateInputB;
    logic        irq;
    logic [31:0] rd;
    int          miscompares;
    int          comparisons;

    dual_counter_timer u_dual_counter_timer (
        .clk       (clk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (3'h2),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .eventPinA (eventPinA),
        .eventPinB (eventPinB),
        .gateInputA(gateInputA),
        .gateInputB(gateInputB),
        .irq       (irq)
    );

    pin_partner u_pin_partner (
        .clk       (clk),
        .eventPinA (eventPinA),
        .eventPinB (eventPinB),
        .gateInputA(gateInputA),
        .gateInputB(gateInputB)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The ready sampled with the edge is the pre-edge level, as the bus requires.
    task automatic busWr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        @(posedge clk iff hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk iff hreadyout);
    endtask

    task automatic busRd(input logic [7:0] a);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        @(posedge clk iff hreadyout);
        htrans <= 2'h0;
        @(posedge clk iff hreadyout);
        rd = hrdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic resetAndMap();
        busRd(`OFS_TIMER_MODE);
        chk("mode reset", 32'h00000000, rd);
        chk("hresp", 32'h00000000, {31'h0, hresp});
        busWr(`OFS_TIMER_MODE, 32'h000000A5);
        busRd(`OFS_TIMER_MODE);
        chk("mode readback", 32'h000000A5, rd);
        busWr(8'h40, 32'h0000005A);
        busRd(8'h40);
        chk("unmapped", 32'h00000000, rd);
        busWr(`OFS_B_HIGH, 32'h0000003C);
        busRd(`OFS_B_HIGH);
        chk("b high byte", 32'h0000003C, rd);
    endtask

    task automatic wrap13();
        busWr(`OFS_CLOCK_CTRL, 32'h00000004);
        busWr(`OFS_TIMER_MODE, 32'h00000000);
        busWr(`OFS_A_HIGH, 32'h000000FF);
        busWr(`OFS_A_LOW, 32'h0000001F);
        busWr(`OFS_IRQ_ENABLE, 32'h00000000);
        busWr(`OFS_TIMER_CTRL, 32'h00000001);
        idle(4);
        busRd(`OFS_STATUS);
        chk("13 bit wrap flag", 32'h00000001, rd);
        chk("masked irq", 32'h00000000, {31'h0, irq});
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busRd(`OFS_A_HIGH);
        chk("13 bit high", 32'h00000000, rd);
        busRd(`OFS_A_LOW);
        chk("13 bit low under 8", 32'h00000000, rd & 32'h00000018);
        busWr(`OFS_IRQ_ENABLE, 32'h00000001);
        idle(2);
        chk("irq enabled", 32'h00000001, {31'h0, irq});
        busWr(`OFS_STATUS, 32'h00000001);
        idle(2);
        chk("irq cleared", 32'h00000000, {31'h0, irq});
    endtask

    task automatic countB16();
        busWr(`OFS_TIMER_MODE, 32'h000000D0);
        busWr(`OFS_EXT_CFG, 32'h00000002);
        busWr(`OFS_B_LOW, 32'h000000FE);
        busWr(`OFS_B_HIGH, 32'h000000FF);
        busWr(`OFS_IRQ_ENABLE, 32'h00000002);
        busWr(`OFS_TIMER_CTRL, 32'h00000002);
        u_pin_partner.pulses(1'b1, 2);
        busRd(`OFS_B_LOW);
        chk("gate closed", 32'h000000FE, rd);
        u_pin_partner.setGate(1'b1, 1'b1);
        u_pin_partner.pulses(1'b1, 2);
        busRd(`OFS_B_LOW);
        chk("b low after edges", 32'h00000000, rd);
        busRd(`OFS_B_HIGH);
        chk("16 bit wrap high", 32'h00000000, rd);
        busRd(`OFS_STATUS);
        chk("b flag", 32'h00000002, rd);
        chk("b irq", 32'h00000001, {31'h0, irq});
        busWr(`OFS_EXT_CFG, 32'h00000000);
        u_pin_partner.pulses(1'b1, 1);
        busRd(`OFS_B_LOW);
        chk("polarity low", 32'h00000000, rd);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busWr(`OFS_STATUS, 32'h00000003);
        u_pin_partner.setGate(1'b1, 1'b0);
    endtask

    // Ten idle clocks plus the two edges of the stopping write give twelve counts.
    task automatic sysclkA16();
        busWr(`OFS_CLOCK_CTRL, 32'h00000004);
        busWr(`OFS_TIMER_MODE, 32'h00000001);
        busWr(`OFS_A_LOW, 32'h00000000);
        busWr(`OFS_A_HIGH, 32'h00000000);
        busWr(`OFS_TIMER_CTRL, 32'h00000001);
        idle(10);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busRd(`OFS_A_LOW);
        chk("sysclk count", 32'h0000000C, rd);
        busRd(`OFS_A_HIGH);
        chk("sysclk high", 32'h00000000, rd);
    endtask

    task automatic eventA16();
        busWr(`OFS_TIMER_MODE, 32'h0000000D);
        busWr(`OFS_EXT_CFG, 32'h00000000);
        busWr(`OFS_A_LOW, 32'h00000000);
        busWr(`OFS_A_HIGH, 32'h00000000);
        busWr(`OFS_TIMER_CTRL, 32'h00000001);
        u_pin_partner.pulses(1'b0, 3);
        busRd(`OFS_A_LOW);
        chk("a event count", 32'h00000003, rd);
        u_pin_partner.setGate(1'b0, 1'b1);
        u_pin_partner.pulses(1'b0, 1);
        busRd(`OFS_A_LOW);
        chk("a gate low active", 32'h00000003, rd);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        u_pin_partner.setGate(1'b0, 1'b0);
    endtask

    task automatic reload8();
        busWr(`OFS_CLOCK_CTRL, 32'h00000004);
        busWr(`OFS_TIMER_MODE, 32'h00000002);
        busWr(`OFS_A_HIGH, 32'h000000F0);
        busWr(`OFS_A_LOW, 32'h000000FE);
        busWr(`OFS_TIMER_CTRL, 32'h00000001);
        idle(4);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busRd(`OFS_STATUS);
        chk("reload flag", 32'h00000001, rd);
        busRd(`OFS_A_HIGH);
        chk("reload value kept", 32'h000000F0, rd);
        busRd(`OFS_A_LOW);
        chk("reloaded low", 32'h000000F0, rd & 32'h000000F0);
        busWr(`OFS_STATUS, 32'h00000003);
    endtask

    task automatic split8();
        busWr(`OFS_TIMER_MODE, 32'h00000003);
        busWr(`OFS_A_LOW, 32'h00000055);
        busWr(`OFS_A_HIGH, 32'h000000FE);
        busWr(`OFS_TIMER_CTRL, 32'h00000002);
        idle(4);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busRd(`OFS_STATUS);
        chk("split flag b", 32'h00000002, rd);
        busRd(`OFS_A_LOW);
        chk("split low idle", 32'h00000055, rd);
        busWr(`OFS_STATUS, 32'h00000003);
    endtask

    // Divide by four over about forty clocks; sysclk would give about forty.
    task automatic prescaled();
        busWr(`OFS_CLOCK_CTRL, 32'h00000000);
        busWr(`OFS_TIMER_MODE, 32'h00000001);
        busWr(`OFS_A_LOW, 32'h00000000);
        busWr(`OFS_A_HIGH, 32'h00000000);
        busWr(`OFS_TIMER_CTRL, 32'h00000001);
        idle(40);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busRd(`OFS_A_LOW);
        chk("prescaled count", 32'h00000001,
            {31'h0, rd >= 32'h00000009 && rd <= 32'h0000000C});
        // Sixty-four clocks at the largest scale hold exactly two ticks, whatever the phase.
        busWr(`OFS_CLOCK_CTRL, 32'h00000003);
        busWr(`OFS_A_LOW, 32'h00000000);
        busWr(`OFS_A_HIGH, 32'h00000000);
        busWr(`OFS_TIMER_CTRL, 32'h00000001);
        idle(62);
        busWr(`OFS_TIMER_CTRL, 32'h00000000);
        busRd(`OFS_A_LOW);
        chk("divide by 32 count", 32'h00000002, rd);
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        resetAndMap();
        wrap13();
        countB16();
        reload8();
        split8();
        sysclkA16();
        eventA16();
        prescaled();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule // dual_counter_timer_tb
